// >>> rtl/spi_control_pkg.sv
// Package: offsets, field positions, reset values and engine states of the serial block
// Assumes: byte-wide register port, bus clock of 200 MHz
package spi_control_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFF_CTRL1 = 3'h0;
    localparam logic [2:0] OFF_CTRL2 = 3'h1;
    localparam logic [2:0] OFF_BAUD = 3'h2;
    localparam logic [2:0] OFF_STATUS = 3'h3;
    localparam logic [2:0] OFF_DATA = 3'h4;
    // Control one field positions
    localparam int C1_RXIE = 7;
    localparam int C1_EN = 6;
    localparam int C1_TXIE = 5;
    localparam int C1_MASTER_SELECT = 4;
    localparam int C1_CPOL = 3;
    localparam int C1_CPHA = 2;
    localparam int C1_SELECT_OUTPUT_ENABLE = 1;
    localparam int C1_LSBF = 0;
    // Control two field positions
    localparam int C2_FAULTEN = 4;
    localparam int C2_SWOE = 3;
    localparam int C2_SWAI = 1;
    localparam int C2_SWSEL = 0;
    localparam logic [7:0] C2_MASK = 8'h1B;
    // Bit rate fields
    localparam int BAUD_PRE_LSB = 4;
    localparam int BAUD_RATE_LSB = 0;
    localparam logic [7:0] BAUD_MASK = 8'h77;
    // Status field positions
    localparam int ST_RXFULL = 7;
    localparam int ST_TXEMPTY = 5;
    localparam int ST_MODE_FAULT_FLAG = 4;
    // Reset values
    localparam logic [7:0] CTRL1_RESET = 8'h04;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    // Sixteen clock edges per byte
    localparam logic [3:0] EDGE_LAST = 4'hF;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_FINISH = 2'b11
    } engine_state_type;
endpackage : spi_control_pkg

// >>> rtl/rate_if.sv
// Interface: bit rate selection and half-period tick between engine and divider
// Assumes: one clock domain
`timescale 1ns/100ps
`default_nettype none
interface rate_if;
    logic [2:0] prescale;
    logic [2:0] rate;
    logic run;
    logic tick;
    modport gen (input prescale, input rate, input run, output tick);
    modport user (output prescale, output rate, output run, input tick);
endinterface : rate_if
`default_nettype wire

// >>> rtl/spi_rate_gen.sv
// Divider: one-cycle tick every half period of the master bit clock
// Assumes: run held high only while a master byte is in progress
`timescale 1ns/100ps
`default_nettype none
module spi_rate_gen
    import spi_control_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    rate_if.gen rateBus
);
    logic [2:0] preCnt;
    logic [2:0] next_preCnt;
    logic [6:0] rateCnt;
    logic [6:0] next_rateCnt;
    logic tick;
    logic next_tick;
    logic [7:0] span;

    always_comb
    begin
        span = (8'h01 << rateBus.rate) - 8'h01;
        next_preCnt = preCnt;
        next_rateCnt = rateCnt;
        next_tick = 1'b0;
        if (!rateBus.run)
        begin
            next_preCnt = 3'h0;
            next_rateCnt = 7'h00;
        end
        else if (preCnt == rateBus.prescale)
        begin
            next_preCnt = 3'h0;
            if (rateCnt == span[6:0])
            begin
                next_rateCnt = 7'h00;
                next_tick = 1'b1;
            end
            else
            begin
                next_rateCnt = rateCnt + 7'h01;
            end
        end
        else
        begin
            next_preCnt = preCnt + 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            preCnt <= 3'h0;
            rateCnt <= 7'h00;
            tick <= 1'b0;
        end
        else
        begin
            preCnt <= next_preCnt;
            rateCnt <= next_rateCnt;
            tick <= next_tick;
        end
    end

    assign rateBus.tick = tick;

    tick_fastest_a: assert property (@(posedge clk) disable iff (!resetn)
        (rateBus.run && rateBus.prescale == 3'h0 && rateBus.rate == 3'h0)[*3] |-> (tick || $past(tick)))
        else $error("fastest rate does not tick every other cycle");
endmodule : spi_rate_gen
`default_nettype wire

// >>> rtl/spi_control_config.sv
// Top: registers, transfer engine and pin control of the byte-wide serial block
// Assumes: pin inputs synchronous to clk; outside logic resolves pins from the enables
//
// Function
// - Five byte registers: control one, control two, bit rate, status, data.
// - Receive-full or fault raises the interrupt when its enable is set.
// - Clearing enable aborts transfer, flushes buffers, returns engine to idle.
// - While disabled, receive-full reads zero and transmit-empty reads one.
// - Transmit-empty raises the interrupt when its enable is set.
// - Control one bit 4 selects slave at zero, master at one.
// - Polarity bit zero idles clock low, one idles it high.
// - Phase zero puts first edge mid-bit, phase one at bit start.
// - Bit 0 selects most significant first at zero, least at one.
// - As slave, select pin is always the active-low select input.
// - As master without fault enable, select pin is left to the port.
// - Master with fault enable: fault input, or automatic select output.
// - Control two bits 7, 6, 5 and 2 read as zero.
// - In single-wire mode bit 3 drives the shared pin, else input.
// - Without single-wire mode the output-enable bit has no effect.
// - Stop-in-wait bit freezes the transfer engine and bit clock while the processor waits.
// - Single-wire mode uses MISO as slave, MOSI as master.
// - Bit clock is bus clock over prescale 1..8 times divisor 2..256.
// - Master drives clock and MOSI, samples MISO; slave the reverse.
// - Receive-full sets at byte end, clears by status then data read.
// - Data writes count only after status read with transmit-empty set.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module spi_control_config
    import spi_control_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [7:0] readData,
    output logic irq,
    input wire logic waitMode,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe,
    input wire logic selectIn,
    output logic selectOut,
    output logic selectOe
);
    logic [7:0] ctrl1, next_ctrl1;
    logic [7:0] ctrl2, next_ctrl2;
    logic [7:0] baud, next_baud;
    logic [7:0] txBuf, next_txBuf;
    logic [7:0] rxBuf, next_rxBuf;
    logic rxFull, next_rxFull;
    logic txEmpty, next_txEmpty;
    logic modeFault, next_modeFault;
    logic rxArm, next_rxArm;
    logic txArm, next_txArm;
    logic faultArm, next_faultArm;
    logic [7:0] next_readData;
    logic next_irq;
    engine_state_type state, next_state;
    logic [3:0] edgeCnt, next_edgeCnt;
    logic [7:0] txShift, next_txShift;
    logic [7:0] rxShift, next_rxShift;
    logic sckLevel, next_sckLevel;
    logic sckPrev;
    logic next_sckOut, next_sckOe, next_mosiOut, next_mosiOe;
    logic next_misoOut, next_misoOe, next_selectOut, next_selectOe;
    logic enable, master, cpol, cpha, lsbFirst, select_output_enable, faultEn, swOe, swSel;
    logic frozen, faultDetect, loadTx, finishing, edgeSeen, inBit, outBit;

    rate_if rateBus ();

    spi_rate_gen rateGen (
        .clk(clk),
        .resetn(resetn),
        .rateBus(rateBus)
    );

    // Shift by one place in the chosen direction, inserting bit b
    function automatic logic [7:0] shiftIn(input logic [7:0] v, input logic b, input logic lsb);
        shiftIn = lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction : shiftIn

    assign enable = ctrl1[C1_EN];
    assign master = ctrl1[C1_MASTER_SELECT];
    assign cpol = ctrl1[C1_CPOL];
    assign cpha = ctrl1[C1_CPHA];
    assign lsbFirst = ctrl1[C1_LSBF];
    assign select_output_enable = ctrl1[C1_SELECT_OUTPUT_ENABLE];
    assign faultEn = ctrl2[C2_FAULTEN];
    assign swOe = ctrl2[C2_SWOE];
    assign swSel = ctrl2[C2_SWSEL];
    assign frozen = ctrl2[C2_SWAI] && waitMode;
    assign faultDetect = enable && master && faultEn && !select_output_enable && !selectIn;
    assign outBit = lsbFirst ? next_txShift[0] : next_txShift[7];
    assign finishing = (state == ST_FINISH) && enable;
    assign rateBus.prescale = baud[BAUD_PRE_LSB +: 3];
    assign rateBus.rate = baud[BAUD_RATE_LSB +: 3];
    assign rateBus.run = enable && master && !frozen && (state == ST_ACTIVE);

    // Input source and edge source by role
    always_comb
    begin
        if (master)
        begin
            inBit = swSel ? mosiIn : misoIn;
            edgeSeen = rateBus.tick;
        end
        else
        begin
            inBit = swSel ? misoIn : mosiIn;
            edgeSeen = (sckIn != sckPrev) && !selectIn;
        end
    end

    // Register file and flags
    always_comb
    begin
        next_ctrl1 = ctrl1;
        next_ctrl2 = ctrl2;
        next_baud = baud;
        next_txBuf = txBuf;
        next_rxBuf = rxBuf;
        next_rxFull = rxFull;
        next_txEmpty = txEmpty;
        next_modeFault = modeFault;
        next_rxArm = rxArm;
        next_txArm = txArm;
        next_faultArm = faultArm;
        next_readData = 8'h00;
        if (readStrobe)
        begin
            case (addr)
                OFF_CTRL1: next_readData = ctrl1;
                OFF_CTRL2: next_readData = ctrl2 & C2_MASK;
                OFF_BAUD: next_readData = baud & BAUD_MASK;
                OFF_STATUS:
                begin
                    next_readData[ST_RXFULL] = rxFull;
                    next_readData[ST_TXEMPTY] = txEmpty;
                    next_readData[ST_MODE_FAULT_FLAG] = modeFault;
                    next_rxArm = rxFull;
                    next_txArm = txEmpty;
                    next_faultArm = modeFault;
                end
                OFF_DATA:
                begin
                    next_readData = rxBuf;
                    if (rxArm)
                    begin
                        next_rxFull = 1'b0;
                        next_rxArm = 1'b0;
                    end
                end
                default: next_readData = 8'h00;
            endcase
        end
        if (writeStrobe)
        begin
            case (addr)
                OFF_CTRL1:
                begin
                    next_ctrl1 = writeData;
                    if (faultArm)
                    begin
                        next_modeFault = 1'b0;
                        next_faultArm = 1'b0;
                    end
                end
                OFF_CTRL2: next_ctrl2 = writeData & C2_MASK;
                OFF_BAUD: next_baud = writeData & BAUD_MASK;
                OFF_DATA:
                begin
                    if (txArm && enable)
                    begin
                        next_txBuf = writeData;
                        next_txEmpty = 1'b0;
                        next_txArm = 1'b0;
                    end
                end
                default: next_baud = baud;
            endcase
        end
        // Hardware events win over software clears
        if (loadTx)
        begin
            next_txEmpty = 1'b1;
        end
        if (finishing)
        begin
            next_rxBuf = rxShift;
            next_rxFull = 1'b1;
        end
        if (faultDetect)
        begin
            next_modeFault = 1'b1;
            next_ctrl1[C1_MASTER_SELECT] = 1'b0;
        end
        if (!enable)
        begin
            next_rxFull = 1'b0;
            next_txEmpty = 1'b1;
            next_rxArm = 1'b0;
            next_txArm = 1'b0;
        end
        next_irq = (ctrl1[C1_RXIE] && (rxFull || modeFault)) || (ctrl1[C1_TXIE] && txEmpty);
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ctrl1 <= CTRL1_RESET;
            ctrl2 <= CTRL2_RESET;
            baud <= BAUD_RESET;
            txBuf <= 8'h00;
            rxBuf <= 8'h00;
            rxFull <= 1'b0;
            txEmpty <= 1'b1;
            modeFault <= 1'b0;
            rxArm <= 1'b0;
            txArm <= 1'b0;
            faultArm <= 1'b0;
            readData <= 8'h00;
            irq <= 1'b0;
        end
        else
        begin
            ctrl1 <= next_ctrl1;
            ctrl2 <= next_ctrl2;
            baud <= next_baud;
            txBuf <= next_txBuf;
            rxBuf <= next_rxBuf;
            rxFull <= next_rxFull;
            txEmpty <= next_txEmpty;
            modeFault <= next_modeFault;
            rxArm <= next_rxArm;
            txArm <= next_txArm;
            faultArm <= next_faultArm;
            readData <= next_readData;
            irq <= next_irq;
        end
    end

    // Transfer engine
    always_comb
    begin
        next_state = state;
        next_edgeCnt = edgeCnt;
        next_txShift = txShift;
        next_rxShift = rxShift;
        next_sckLevel = sckLevel;
        loadTx = 1'b0;
        if (!enable || faultDetect)
        begin
            next_state = ST_IDLE;
            next_edgeCnt = 4'h0;
            next_sckLevel = 1'b0;
        end
        else if (!frozen)
        begin
            case (state)
                ST_IDLE:
                begin
                    next_edgeCnt = 4'h0;
                    next_sckLevel = 1'b0;
                    if ((master && !txEmpty) || (!master && !selectIn))
                    begin
                        next_state = ST_ACTIVE;
                        loadTx = !txEmpty;
                        if (!txEmpty)
                        begin
                            next_txShift = txBuf;
                        end
                    end
                end
                ST_ACTIVE:
                begin
                    if (!master && selectIn)
                    begin
                        next_state = ST_IDLE;
                    end
                    else if (edgeSeen)
                    begin
                        next_sckLevel = !sckLevel;
                        if (edgeCnt[0] == cpha)
                        begin
                            next_rxShift = shiftIn(rxShift, inBit, lsbFirst);
                        end
                        else if (edgeCnt != 4'h0)
                        begin
                            next_txShift = shiftIn(txShift, 1'b0, lsbFirst);
                        end
                        next_edgeCnt = edgeCnt + 4'h1;
                        if (edgeCnt == EDGE_LAST)
                        begin
                            next_state = ST_FINISH;
                        end
                    end
                end
                ST_FINISH: next_state = ST_IDLE;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state <= ST_IDLE;
            edgeCnt <= 4'h0;
            txShift <= 8'h00;
            rxShift <= 8'h00;
            sckLevel <= 1'b0;
            sckPrev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            edgeCnt <= next_edgeCnt;
            txShift <= next_txShift;
            rxShift <= next_rxShift;
            sckLevel <= next_sckLevel;
            sckPrev <= sckIn;
        end
    end

    // Pin control from next values, so pin edges line up with sampling
    always_comb
    begin
        next_sckOe = enable && master;
        next_sckOut = next_sckOe && (next_sckLevel ^ cpol);
        next_mosiOut = 1'b0;
        next_mosiOe = 1'b0;
        next_misoOut = 1'b0;
        next_misoOe = 1'b0;
        next_selectOut = 1'b1;
        next_selectOe = 1'b0;
        if (enable && master)
        begin
            next_mosiOut = outBit;
            next_mosiOe = swSel ? swOe : 1'b1;
            if (faultEn && select_output_enable)
            begin
                next_selectOe = 1'b1;
                next_selectOut = (next_state == ST_IDLE);
            end
        end
        else if (enable && !selectIn)
        begin
            next_misoOut = outBit;
            next_misoOe = swSel ? swOe : 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sckOut <= 1'b0;
            sckOe <= 1'b0;
            mosiOut <= 1'b0;
            mosiOe <= 1'b0;
            misoOut <= 1'b0;
            misoOe <= 1'b0;
            selectOut <= 1'b1;
            selectOe <= 1'b0;
        end
        else
        begin
            sckOut <= next_sckOut;
            sckOe <= next_sckOe;
            mosiOut <= next_mosiOut;
            mosiOe <= next_mosiOe;
            misoOut <= next_misoOut;
            misoOe <= next_misoOe;
            selectOut <= next_selectOut;
            selectOe <= next_selectOe;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    irq_tx_a: assert property (ctrl1[C1_TXIE] && txEmpty |=> irq)
        else $error("transmit empty did not raise interrupt");
    irq_rx_a: assert property (ctrl1[C1_RXIE] && (rxFull || modeFault) |=> irq)
        else $error("receive full or fault did not raise interrupt");
    irq_polled_a: assert property (!ctrl1[C1_RXIE] && !ctrl1[C1_TXIE] |=> !irq)
        else $error("interrupt raised with both enables off");
    disable_flush_a: assert property (!enable |=> !rxFull && txEmpty && state == ST_IDLE)
        else $error("disable did not flush flags and engine");
    ctrl2_zero_a: assert property (readStrobe && addr == OFF_CTRL2 |=> readData[7:5] == 3'h0 && !readData[2])
        else $error("unimplemented control two bits read nonzero");
    slave_select_a: assert property (!master |=> !selectOe)
        else $error("slave drives the select pin");
    master_gpio_a: assert property (master && !faultEn |=> !selectOe)
        else $error("select pin driven without fault enable");
    fault_drop_a: assert property (faultDetect |=> modeFault && !master)
        else $error("fault input did not set flag and drop master");
    single_wire_a: assert property (enable && master && swSel |=> mosiOe == $past(swOe) && !misoOe)
        else $error("shared pin direction wrong in single-wire master");
    rx_full_a: assert property (finishing |=> rxFull && rxBuf == $past(rxShift))
        else $error("finished byte not stored in receive buffer");
    write_ignored_a: assert property (writeStrobe && addr == OFF_DATA && !txArm && txEmpty |=> txEmpty)
        else $error("unarmed data write accepted");
    wait_freeze_a: assert property (frozen && enable && !faultDetect |=> $stable(edgeCnt) && $stable(state))
        else $error("engine moved while stopped in wait");

    master_byte_c: cover property (master && state == ST_ACTIVE ##[1:300] finishing);
    slave_byte_c: cover property (!master && state == ST_ACTIVE ##[1:300] finishing);
    mode_fault_c: cover property (faultDetect);
    single_wire_c: cover property (enable && swSel && finishing);
endmodule : spi_control_config
`default_nettype wire

// >>> tb/spi_far_end.sv
// Far-end serial slave model: one byte in and one byte out per frame
// Assumes: clock and select come from the master under test
`timescale 1ns/100ps
`default_nettype none
module spi_far_end
(
    input wire logic sck,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsbFirst,
    input wire logic selectN,
    input wire logic mosi,
    input wire logic [7:0] txByte,
    output logic miso,
    output logic [7:0] rxByte
);
    logic [7:0] sh;
    initial miso = 1'b0;
    always @(negedge selectN)
    begin
        sh = txByte;
        if (!cpha)
            miso = lsbFirst ? sh[0] : sh[7];
    end
    always @(posedge selectN)
        miso = ~miso;
    always @(sck)
    begin
        if (!selectN && ((sck != cpol) != cpha))
        begin
            sh = lsbFirst ? {mosi, sh[7:1]} : {sh[6:0], mosi};
            rxByte = sh;
        end
        else if (!selectN)
            miso = lsbFirst ? sh[0] : sh[7];
    end
endmodule : spi_far_end
`default_nettype wire

// >>> tb/test_spi_control_config.sv
// Testbench: register port, pin enables, master transfers in every polarity, phase and bit order, slave transfers in both phases, abort and fault
// Assumes: far-end model on the serial pins, bench resolves shared pins
`timescale 1ns/100ps
`default_nettype none
module test_spi_control_config;
    import spi_control_pkg::*;
    logic clk = 0, resetn = 0, writeStrobe = 0, readStrobe = 0, waitMode = 0, selectIn = 1;
    logic [ADDR_W-1:0] addr = '0;
    logic [7:0] writeData = 8'h00, rdv, d, p, farTx = 8'h00, cfg;
    logic [7:0] readData, farRx;
    logic irq, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, selectOut, selectOe, miso;
    logic cpolSet = 0, cphaSet = 0, lsbSet = 0, sckDrv = 0, mosiDrv = 1;
    integer seed = 2755, fails = 0, nCompared = 0, cycles = 0, i, k;
    logic [7:0] expQ[$];
    spi_control_config u_spi_control_config (.clk(clk), .resetn(resetn), .addr(addr), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData), .irq(irq), .waitMode(waitMode),
        .sckIn(sckOe ? sckOut : sckDrv), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiOe ? mosiOut : mosiDrv),
        .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoOe ? misoOut : miso), .misoOut(misoOut),
        .misoOe(misoOe), .selectIn(selectIn), .selectOut(selectOut), .selectOe(selectOe));
    spi_far_end u_spi_far_end (.sck(sckOut), .cpol(cpolSet), .cpha(cphaSet), .lsbFirst(lsbSet),
        .selectN(selectOe ? selectOut : 1'b1), .mosi(mosiOut), .txByte(farTx), .miso(miso), .rxByte(farRx));
    initial forever #2.5 clk = ~clk;
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        writeData <= v;
        writeStrobe <= 1;
        @(posedge clk);
        writeStrobe <= 0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        readStrobe <= 1;
        @(posedge clk);
        readStrobe <= 0;
        #1 v = readData;
    endtask : rd
    task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
        logic [7:0] v;
        rd(a, v);
        chk(n, v, e);
    endtask : rc
    task automatic slaveByte(input logic ph, input logic [7:0] mo, input logic [7:0] so);
        logic [7:0] got;
        integer e, j;
        got = 8'h00;
        j = 7;
        wr(OFF_CTRL1, {5'h18, ph, 2'b00});
        rd(OFF_STATUS, rdv);
        wr(OFF_DATA, so);
        @(posedge clk);
        selectIn <= 0;
        mosiDrv <= mo[7];
        for (e = 0; e < 16; e++)
        begin
            repeat (4) @(posedge clk);
            sckDrv <= ~sckDrv;
            if (e[0] == ph)
            begin
                got[j] = misoOut;
                j--;
            end
            else if (j >= 0)
                mosiDrv <= mo[j];
        end
        @(posedge clk);
        selectIn <= 1;
        rc(OFF_STATUS, 8'hA0, "slave status");
        rc(OFF_DATA, mo, "slave rx");
        chk("slave tx", got, so);
    endtask : slaveByte
    task automatic pin(input logic [7:0] c1, input logic [7:0] c2, input logic [3:0] e);
        wr(OFF_CTRL2, c2);
        wr(OFF_CTRL1, c1);
        repeat (2) @(posedge clk);
        #1 chk("pin enables", {4'h0, sckOe, mosiOe, misoOe, selectOe}, {4'h0, e});
    endtask : pin
    task automatic wrapUp;
        $display("compared %0d mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrapUp
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            fails++;
            wrapUp();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1;
        rc(OFF_CTRL1, CTRL1_RESET, "ctrl1 reset");
        rc(OFF_STATUS, 8'h20, "status reset");
        rc(3'h5, 8'h00, "unmapped");
        wr(OFF_CTRL2, 8'hFF);
        rc(OFF_CTRL2, 8'h1B, "ctrl2 mask");
        wr(OFF_BAUD, 8'hFF);
        rc(OFF_BAUD, 8'h77, "bit rate");
        $display("test registers done");
        pin(8'h50, 8'h1B, 4'b1100);
        pin(8'h50, 8'h11, 4'b1000);
        pin(8'h52, 8'h08, 4'b1100);
        pin(8'h52, 8'h10, 4'b1101);
        pin(8'h40, 8'h10, 4'b0000);
        wr(OFF_CTRL1, 8'h60);
        repeat (2) @(posedge clk);
        #1 chk("irq tx", {7'h0, irq}, 8'h01);
        wr(OFF_CTRL1, 8'h40);
        repeat (2) @(posedge clk);
        #1 chk("irq off", {7'h0, irq}, 8'h00);
        $display("test pins done");
        for (k = 0; k < 8; k++)
        begin
            {lsbSet, cphaSet, cpolSet} = k[2:0];
            wr(OFF_BAUD, (k == 0) ? 8'h00 :
                {1'b0, 2'b00, 1'($random(seed)), 1'b0, 2'b00, 1'b1} + {5'h0, 1'($random(seed)), 2'b00});
            cfg = {4'hD, cpolSet, cphaSet, 1'b1, lsbSet};
            wr(OFF_CTRL1, cfg);
            repeat (2) @(posedge clk);
            #1 chk("clock idle", {7'h0, sckOut}, {7'h0, cpolSet});
            d = $random(seed);
            p = $random(seed);
            farTx = p;
            expQ.push_back(p);
            rd(OFF_STATUS, rdv);
            wr(OFF_DATA, d);
            rdv = 8'h00;
            for (i = 0; i < 600 && rdv[7] !== 1'b1; i++)
                rd(OFF_STATUS, rdv);
            chk("irq rx", {7'h0, irq}, 8'h01);
            rc(OFF_DATA, expQ.pop_front(), "rx data");
            chk("far rx", farRx, d);
            rc(OFF_STATUS, 8'h20, "status cleared");
        end
        $display("test transfers done");
        wr(OFF_BAUD, 8'h01);
        wr(OFF_CTRL1, cfg & 8'hBF);
        wr(OFF_CTRL1, cfg);
        wr(OFF_DATA, 8'hA5);
        repeat (300) @(posedge clk);
        rc(OFF_STATUS, 8'h20, "unarmed write");
        wr(OFF_DATA, 8'h3C);
        wr(OFF_CTRL2, 8'h12);
        waitMode <= 1;
        repeat (300) @(posedge clk);
        rc(OFF_STATUS, 8'h20, "frozen in wait");
        waitMode <= 0;
        repeat (20) @(posedge clk);
        wr(OFF_CTRL1, 8'h9F);
        rc(OFF_STATUS, 8'h20, "abort status");
        repeat (300) @(posedge clk);
        rc(OFF_STATUS, 8'h20, "no late byte");
        chk("idle enables", {6'h0, sckOe, irq}, 8'h00);
        $display("test abort done");
        wr(OFF_CTRL2, 8'h10);
        wr(OFF_CTRL1, 8'hD4);
        selectIn <= 0;
        repeat (3) @(posedge clk);
        selectIn <= 1;
        rc(OFF_STATUS, 8'h30, "fault flag");
        rc(OFF_CTRL1, 8'hC4, "master dropped");
        chk("irq fault", {7'h0, irq}, 8'h01);
        $display("test fault done");
        for (k = 0; k < 2; k++)
        begin
            d = $random(seed);
            p = $random(seed);
            slaveByte(k[0], d, p);
        end
        $display("test slave done");
        wrapUp();
    end
endmodule : test_spi_control_config
`default_nettype wire
